// file: rtl/xor_exec_pkg.sv
// Constants and types shared by the exclusive-OR execution unit
package xor_exec_pkg;
    localparam int unsigned WORD_W        = 14;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned ADDR_W        = 7;
    localparam int unsigned OPC_HI        = 13;
    localparam int unsigned OPC_LO        = 8;
    localparam int unsigned DEST_BIT      = 7;
    localparam int unsigned LIT_HI        = 7;
    localparam int unsigned ADDR_HI       = 6;
    localparam logic [5:0]  OPC_XOR_LIT   = 6'h3a;
    localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [7:0]  DATA_ZERO     = 8'h00;
    localparam logic [6:0]  ADDR_RESET    = 7'h00;
    localparam logic        DEST_TO_ACC   = 1'b0;
    localparam logic        DEST_TO_FILE  = 1'b1;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_type;

    typedef enum logic [2:0] {
        OP_NONE = 3'b001,
        OP_LIT  = 3'b010,
        OP_FILE = 3'b100
    } op_type;
endpackage

// file: rtl/phase_if.sv
// Instruction-cycle phase carried from the sequencer to the datapath
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
    import xor_exec_pkg::*;
    phase_type phase;
    modport gen (output phase);
    modport use_side (input phase);
endinterface
`default_nettype wire

// file: rtl/q_phase_gen.sv
// Four-phase instruction-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module q_phase_gen (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Phase out
    phase_if.gen      ph
);
    import xor_exec_pkg::*;

    phase_type phase_reg;
    phase_type phase_next;

    always_comb begin
        unique case (phase_reg)
            PH_Q1: phase_next = PH_Q2;
            PH_Q2: phase_next = PH_Q3;
            PH_Q3: phase_next = PH_Q4;
            PH_Q4: phase_next = PH_Q1;
            // Recovers from an upset code instead of locking up
            default: phase_next = PH_Q1;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= PH_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign ph.phase = phase_reg;
endmodule
`default_nettype wire

// file: rtl/exclusive_or_instruction_exec.sv
// Decode and datapath for the two exclusive-OR instructions
// Summary of operation
// RULE1: opcode 11 1010 with low eight bits as literal is literal XOR
// RULE2: literal form XORs accumulator with the eight-bit literal
// RULE3: literal result goes to accumulator; only zero flag follows the result
// RULE4: opcode 00 0110, then destination bit, then seven-bit file address
// RULE5: file form XORs addressed file register with accumulator, updates zero flag
// RULE6: destination bit 0 writes accumulator, file register untouched
// RULE7: destination bit 1 writes file register, accumulator untouched
// RULE8: one word, one cycle: decode, read, compute, write in Q1..Q4
`timescale 1ns/1ps
`default_nettype none
module exclusive_or_instruction_exec (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // Instruction word, sampled in the first phase
    input  wire logic [xor_exec_pkg::WORD_W-1:0] instr_word,
    // Data memory port
    input  wire logic [xor_exec_pkg::DATA_W-1:0] file_rd_data,
    output logic      [xor_exec_pkg::ADDR_W-1:0] file_addr,
    output logic                              file_rd_en,
    output logic                              file_wr_en,
    output logic      [xor_exec_pkg::DATA_W-1:0] file_wr_data,
    // Core state
    output logic      [xor_exec_pkg::DATA_W-1:0] acc_out,
    output logic                              zero_flag,
    output logic                              first_phase,
    output logic                              exec_done
);
    import xor_exec_pkg::*;

    phase_if ph ();

    q_phase_gen u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .ph       (ph.gen)
    );

    op_type            op_reg,        op_next;
    logic              dest_reg,      dest_next;
    logic [DATA_W-1:0] lit_reg,       lit_next;
    logic [ADDR_W-1:0] addr_reg,      addr_next;
    logic              rd_en_reg,     rd_en_next;
    logic [DATA_W-1:0] operand_reg,   operand_next;
    logic [DATA_W-1:0] result_reg,    result_next;
    logic              wr_en_reg,     wr_en_next;
    logic [DATA_W-1:0] wr_data_reg,   wr_data_next;
    logic [DATA_W-1:0] acc_reg,       acc_next;
    logic              zero_reg,      zero_next;
    logic              first_reg,     first_next;
    logic              done_reg,      done_next;
    logic [5:0]        opcode;

    assign opcode = instr_word[OPC_HI:OPC_LO];

    always_comb begin
        op_next      = op_reg;
        dest_next    = dest_reg;
        lit_next     = lit_reg;
        addr_next    = addr_reg;
        rd_en_next   = 1'b0;
        operand_next = operand_reg;
        result_next  = result_reg;
        wr_en_next   = 1'b0;
        wr_data_next = wr_data_reg;
        acc_next     = acc_reg;
        zero_next    = zero_reg;
        first_next   = (ph.phase == PH_Q4);
        done_next    = 1'b0;
        unique case (ph.phase)
            PH_Q1: begin
                // Decode; any other opcode leaves this unit idle for the cycle
                lit_next  = instr_word[LIT_HI:0];
                dest_next = instr_word[DEST_BIT];
                addr_next = instr_word[ADDR_HI:0];
                if (opcode == OPC_XOR_LIT) begin
                    op_next = OP_LIT; // [RULE1] [RULE8]
                end else if (opcode == OPC_XOR_FILE) begin
                    op_next    = OP_FILE; // [RULE4] [RULE8]
                    rd_en_next = 1'b1;
                end else begin
                    op_next = OP_NONE;
                end
            end
            PH_Q2: begin
                // Memory answers combinationally while the address is held
                operand_next = (op_reg == OP_FILE) ? file_rd_data : lit_reg; // [RULE5] [RULE8]
            end
            PH_Q3: begin
                result_next = acc_reg ^ operand_reg; // [RULE2] [RULE5] [RULE8]
                // Write data has its own flop so it meets memory together with its strobe
                if (op_reg == OP_FILE && dest_reg == DEST_TO_FILE) begin
                    wr_en_next   = 1'b1; // [RULE7]
                    wr_data_next = acc_reg ^ operand_reg;
                end
            end
            PH_Q4: begin
                if (op_reg != OP_NONE) begin
                    zero_next = (result_reg == DATA_ZERO); // [RULE3] [RULE5]
                    done_next = 1'b1;
                    if (op_reg == OP_LIT || dest_reg == DEST_TO_ACC) begin
                        acc_next = result_reg; // [RULE3] [RULE6] [RULE8]
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_reg      <= OP_NONE;
            dest_reg    <= DEST_TO_ACC;
            lit_reg     <= DATA_ZERO;
            addr_reg    <= ADDR_RESET;
            rd_en_reg   <= 1'b0;
            operand_reg <= DATA_ZERO;
            result_reg  <= DATA_ZERO;
            wr_en_reg   <= 1'b0;
            wr_data_reg <= DATA_ZERO;
            acc_reg     <= ACC_RESET;
            zero_reg    <= 1'b0;
            // High out of reset: the word present after release is taken at once
            first_reg   <= 1'b1;
            done_reg    <= 1'b0;
        end else begin
            op_reg      <= op_next;
            dest_reg    <= dest_next;
            lit_reg     <= lit_next;
            addr_reg    <= addr_next;
            rd_en_reg   <= rd_en_next;
            operand_reg <= operand_next;
            result_reg  <= result_next;
            wr_en_reg   <= wr_en_next;
            wr_data_reg <= wr_data_next;
            acc_reg     <= acc_next;
            zero_reg    <= zero_next;
            first_reg   <= first_next;
            done_reg    <= done_next;
        end
    end

    assign file_addr    = addr_reg;
    assign file_rd_en   = rd_en_reg;
    assign file_wr_en   = wr_en_reg;
    assign file_wr_data = wr_data_reg;
    assign acc_out      = acc_reg;
    assign zero_flag    = zero_reg;
    assign first_phase  = first_reg;
    assign exec_done    = done_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Each check starts in one phase and looks up to four phases ahead; write_phase_a looks one phase back

    literal_decode_a: assert property ( // [RULE1]
        ph.phase == PH_Q1 && opcode == OPC_XOR_LIT
        |=> op_reg == OP_LIT && lit_reg == $past(instr_word[LIT_HI:0]))
        else $error("literal opcode not decoded");

    literal_xor_a: assert property ( // [RULE2]
        ph.phase == PH_Q1 && opcode == OPC_XOR_LIT
        |=> ##2 result_reg == ($past(acc_reg, 3) ^ $past(instr_word[LIT_HI:0], 3)))
        else $error("literal xor result wrong");

    literal_write_a: assert property ( // [RULE3]
        ph.phase == PH_Q4 && op_reg == OP_LIT
        |=> acc_reg == $past(result_reg) && zero_reg == ($past(result_reg) == DATA_ZERO)
            && !wr_en_reg)
        else $error("literal result not placed in accumulator");

    file_decode_a: assert property ( // [RULE4]
        ph.phase == PH_Q1 && opcode == OPC_XOR_FILE
        |=> file_rd_en && file_addr == $past(instr_word[ADDR_HI:0])
            && dest_reg == $past(instr_word[DEST_BIT]))
        else $error("file opcode not decoded");

    file_xor_a: assert property ( // [RULE5]
        ph.phase == PH_Q2 && op_reg == OP_FILE
        |=> ##1 result_reg == ($past(acc_reg) ^ $past(file_rd_data, 2)))
        else $error("file xor result wrong");

    dest_acc_a: assert property ( // [RULE6]
        ph.phase == PH_Q4 && op_reg == OP_FILE && dest_reg == DEST_TO_ACC
        |-> !file_wr_en ##1 acc_reg == $past(result_reg))
        else $error("accumulator destination not honoured");

    dest_file_a: assert property ( // [RULE7]
        ph.phase == PH_Q3 && op_reg == OP_FILE && dest_reg == DEST_TO_FILE
        |=> file_wr_en && file_wr_data == $past(acc_reg ^ operand_reg)
            ##1 $stable(acc_reg) && zero_reg == ($past(result_reg) == DATA_ZERO))
        else $error("file destination not honoured");

    phase_order_a: assert property ( // [RULE8]
        ph.phase == PH_Q1 |=> ph.phase == PH_Q2 ##1 ph.phase == PH_Q3
        ##1 ph.phase == PH_Q4 ##1 ph.phase == PH_Q1)
        else $error("instruction cycle is not four phases");

    write_phase_a: assert property ( // [RULE8]
        file_wr_en |-> ph.phase == PH_Q4 && $past(ph.phase) == PH_Q3)
        else $error("file write outside fourth phase");

    refused_opcode_a: assert property ( // [RULE1] [RULE4]
        ph.phase == PH_Q1 && opcode != OPC_XOR_LIT && opcode != OPC_XOR_FILE
        |=> !file_rd_en ##2 !file_wr_en
            ##1 !exec_done && $stable(acc_reg) && $stable(zero_reg))
        else $error("refused opcode changed state");

    read_strobe_a: assert property ( // [RULE4] [RULE8]
        file_rd_en |-> ph.phase == PH_Q2 && op_reg == OP_FILE ##1 !file_rd_en)
        else $error("file read outside second phase");

    done_pulse_a: assert property ( // [RULE8]
        exec_done |-> first_phase && ph.phase == PH_Q1 ##1 !exec_done)
        else $error("completion pulse outside first phase");

    lit_run_c: cover property (ph.phase == PH_Q4 && op_reg == OP_LIT ##1 zero_reg);
    file_acc_c: cover property (ph.phase == PH_Q4 && op_reg == OP_FILE && !dest_reg);
    file_wr_c: cover property (file_wr_en ##1 exec_done);
    file_zero_c: cover property (ph.phase == PH_Q4 && op_reg == OP_FILE ##1 zero_reg);
    refused_c: cover property (ph.phase == PH_Q1 && op_next == OP_NONE);
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the exclusive-OR execution unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import xor_exec_pkg::*;
    logic                core_clk;
    logic                rst;
    logic [WORD_W-1:0]   instr_word;
    logic [DATA_W-1:0]   file_rd_data;
    logic [ADDR_W-1:0]   file_addr;
    logic                file_rd_en;
    logic                file_wr_en;
    logic [DATA_W-1:0]   file_wr_data;
    logic [DATA_W-1:0]   acc_out;
    logic                zero_flag;
    logic                first_phase;
    logic                exec_done;
    logic [DATA_W-1:0]   mem [0:127];
    logic [DATA_W-1:0]   acc_m;
    logic                z_m;
    int                  fail_count;
    int                  n_compared;
    int                  cyc;
    logic [5:0]          bad_opc [0:6] = '{6'h3b, 6'h3e, 6'h07, 6'h16, 6'h0e, 6'h2a, 6'h00};

    exclusive_or_instruction_exec exclusive_or_instruction_exec_i (
        .core_clk(core_clk), .rst(rst), .instr_word(instr_word),
        .file_rd_data(file_rd_data), .file_addr(file_addr), .file_rd_en(file_rd_en),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .acc_out(acc_out),
        .zero_flag(zero_flag), .first_phase(first_phase), .exec_done(exec_done));

    // Read data is only trustworthy while the read strobe is up
    assign file_rd_data = file_rd_en ? mem[file_addr] : ~mem[file_addr];

    always @(posedge core_clk) begin
        if (file_wr_en === 1'b1) begin
            mem[file_addr] <= file_wr_data;
        end
    end

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc++;
        if (cyc >= 4000) begin
            fail_count++;
            $display("[FAIL] cycle_limit expected below %0d seen %0d", 4000, cyc);
            results();
        end
    end

    function automatic logic [7:0] exp_res(input logic [13:0] w, input logic [7:0] acc,
                                           input logic [7:0] f);
        return acc ^ ((w[13:8] == OPC_XOR_LIT) ? w[7:0] : f);
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Presents one word in Q1 and follows it through all four phases
    task automatic run(input logic [13:0] w);
        logic       is_lit;
        logic       is_file;
        logic       to_file;
        logic [7:0] res;
        is_lit = (w[13:8] == OPC_XOR_LIT);
        is_file = (w[13:8] == OPC_XOR_FILE);
        to_file = is_file && w[7];
        res = exp_res(w, acc_m, mem[w[6:0]]);
        chk("first_phase", 8'h01, {7'h00, first_phase});
        instr_word = w;
        @(negedge core_clk);
        instr_word = 14'($urandom);
        chk("file_rd_en q2", {7'h00, is_file}, {7'h00, file_rd_en});
        if (is_file) chk("file_addr", {1'b0, w[6:0]}, {1'b0, file_addr});
        @(negedge core_clk);
        chk("file_rd_en q3", 8'h00, {7'h00, file_rd_en});
        @(negedge core_clk);
        chk("file_wr_en", {7'h00, to_file}, {7'h00, file_wr_en});
        if (to_file) chk("file_wr_data", res, file_wr_data);
        @(negedge core_clk);
        if (is_lit || (is_file && !to_file)) acc_m = res;
        if (is_lit || is_file) z_m = (res == 8'h00);
        chk("acc_out", acc_m, acc_out);
        chk("zero_flag", {7'h00, z_m}, {7'h00, zero_flag});
        chk("exec_done", {7'h00, is_lit || is_file}, {7'h00, exec_done});
        if (to_file) chk("file_mem", res, mem[w[6:0]]);
    endtask

    task automatic reset_check();
        rst = 1'b1;
        @(negedge core_clk);
        chk("acc_rst", ACC_RESET, acc_out);
        chk("zero_rst", 8'h00, {7'h00, zero_flag});
        chk("done_rst", 8'h00, {7'h00, exec_done});
        chk("wr_rst", 8'h00, {7'h00, file_wr_en});
        @(negedge core_clk);
        rst = 1'b0;
        acc_m = ACC_RESET;
        z_m = 1'b0;
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [5:0] opc;
        fail_count = 0;
        n_compared = 0;
        cyc = 0;
        rst = 1'b1;
        instr_word = '0;
        void'($urandom(77777));
        for (int i = 0; i < 128; i++) mem[i] = 8'($urandom);
        reset_check();
        run({OPC_XOR_LIT, 8'hb5});
        run({OPC_XOR_LIT, 8'haf});
        run({OPC_XOR_LIT, 8'h1a});
        mem[127] = 8'h3c;
        run({OPC_XOR_FILE, DEST_TO_FILE, 7'h7f});
        run({OPC_XOR_FILE, DEST_TO_ACC, 7'h7f});
        run({OPC_XOR_FILE, DEST_TO_ACC, 7'h7f});
        run({OPC_XOR_FILE, DEST_TO_FILE, 7'h00});
        for (int i = 0; i < 7; i++) run({bad_opc[i], 8'($urandom)});
        for (int i = 0; i < 200; i++) begin
            case ($urandom_range(0, 2))
                0: opc = OPC_XOR_LIT;
                1: opc = OPC_XOR_FILE;
                default: opc = 6'($urandom);
            endcase
            run({opc, 8'($urandom)});
            if (i == 100) reset_check();
        end
        results();
    end
endmodule
`default_nettype wire
